/* strobe_pio_pkg.sv */
// Shared constants for the strobe pulse and parallel port block
package strobe_pio_pkg;

    // Sizes
    localparam int NUM_CH  = 4;
    localparam int ADDR_W  = 8;
    localparam int DATA_W  = 32;
    localparam int VAL_W   = 12;
    localparam int MULT_W  = 8;
    localparam int ACC_W   = 32;
    localparam int CTRL_W  = 26;

    // Register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] STROBE_CTRL0_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] STROBE_CTRL_END  = 8'h10;
    localparam logic [ADDR_W-1:0] USER_OUT_OFS     = 8'h10;
    localparam logic [ADDR_W-1:0] INPUT_STATE_OFS  = 8'h14;
    localparam logic [ADDR_W-1:0] PORT_CFG_OFS     = 8'h18;
    localparam logic [ADDR_W-1:0] TIME_BASE_OFS    = 8'h1C;
    localparam logic [ADDR_W-1:0] STATUS_OFS       = 8'h20;

    // Strobe channel control fields
    localparam int DUR_LSB = 0;
    localparam int DUR_MSB = 11;
    localparam int DLY_LSB = 12;
    localparam int DLY_MSB = 23;
    localparam int POL_BIT = 24;
    localparam int EN_BIT  = 25;

    // Time base fields, in units of 1/1024 ms
    localparam int TB_DLY_LSB = 0;
    localparam int TB_DUR_LSB = 8;

    // Reset values
    localparam logic [CTRL_W-1:0] STROBE_CTRL_RST = 26'h000_0000;
    localparam logic [3:0]        USER_OUT_RST    = 4'h0;
    localparam logic [3:0]        PORT_CFG_RST    = 4'h0;
    localparam logic [15:0]       TIME_BASE_RST   = 16'h0101;

    // Timing: one base unit is 1/1024 ms, clock period is 5 ns
    localparam int CLK_PERIOD_NS   = 5;
    localparam int NS_PER_MS       = 1_000_000;
    localparam int UNITS_PER_MS    = 1024;
    localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(CLK_PERIOD_NS * UNITS_PER_MS);
    localparam logic [ACC_W-1:0] ACC_UNIT = ACC_W'(NS_PER_MS);
    localparam int UNIT_CYCLES_MAX = (NS_PER_MS + CLK_PERIOD_NS * UNITS_PER_MS - 1) / (CLK_PERIOD_NS * UNITS_PER_MS);

    // Channel phases, Gray along idle -> delay -> active
    typedef enum logic [1:0] {
        PH_IDLE   = 2'b00,
        PH_DELAY  = 2'b01,
        PH_ACTIVE = 2'b11
    } phase_t;

endpackage : strobe_pio_pkg

/* time_base_if.sv */
// Time base multipliers and unit ticks between the block and its tick generator
`timescale 1ns/1ps
interface time_base_if;
    import strobe_pio_pkg::*;
    logic [MULT_W-1:0] dlyMult;
    logic [MULT_W-1:0] durMult;
    logic              restart;
    logic              dlyTick;
    logic              durTick;

    modport gen  (input dlyMult, input durMult, input restart, output dlyTick, output durTick);
    modport user (output dlyMult, output durMult, output restart, input dlyTick, input durTick);
endinterface : time_base_if

/* time_base_gen.sv */
// Fractional tick generator for the delay and duration time bases
`timescale 1ns/1ps
module time_base_gen
    import strobe_pio_pkg::*;
(
    // Clock and reset
    input  wire logic    sys_clk,
    input  wire logic    rst,
    // Multipliers in, ticks out
    time_base_if.gen     tb
);

    typedef struct packed {
        logic [ACC_W-1:0] dlyAcc;
        logic [ACC_W-1:0] durAcc;
    } tb_state_t;

    tb_state_t st_r;
    tb_state_t st_nxt;
    logic [ACC_W-1:0] dlyThr;
    logic [ACC_W-1:0] durThr;

    // A period of 1/1024 ms is not a whole number of cycles, so the remainder is carried
    function automatic logic [ACC_W-1:0] thresh(input logic [MULT_W-1:0] mult);
        logic [ACC_W-1:0] m;
        m = (mult == '0) ? ACC_W'(1) : ACC_W'(mult);
        return ACC_W'(m * ACC_UNIT);
    endfunction : thresh

    always_comb begin
        dlyThr     = thresh(tb.dlyMult);
        durThr     = thresh(tb.durMult);
        tb.dlyTick = (st_r.dlyAcc + ACC_STEP) >= dlyThr;
        tb.durTick = (st_r.durAcc + ACC_STEP) >= durThr;
        st_nxt.dlyAcc = tb.dlyTick ? st_r.dlyAcc + ACC_STEP - dlyThr : st_r.dlyAcc + ACC_STEP;
        st_nxt.durAcc = tb.durTick ? st_r.durAcc + ACC_STEP - durThr : st_r.durAcc + ACC_STEP;
        // Exposure start aligns both bases so the first unit is a whole unit
        if (tb.restart) begin
            st_nxt.dlyAcc = '0;
            st_nxt.durAcc = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule : time_base_gen

/* strobe_pio.sv */
// Four strobe pulse channels with parallel output and input ports
// How it works
// - Four independent strobe channels, 0 to 3, each with its own control register.
// - A channel makes pulses only while its enable bit is 1.
// - Polarity bit 0 gives an active low pulse, 1 an active high pulse.
// - Delay equals the delay value times the delay time base.
// - Delay value is a twelve bit unsigned field, 0 to 4095.
// - After reset the delay time base is one 1/1024 ms unit.
// - Delay runs from exposure start until the strobe turns active.
// - Active time equals the duration value times the duration time base.
// - Duration value is a twelve bit unsigned field, 0 to 4095.
// - After reset the duration time base is one 1/1024 ms unit.
// - Both time bases can be raised by software to reach longer intervals.
// - A strobe reaches its pin only when the port is set to strobe.
// - Strobe channel n can only drive output port n.
// - A new exposure restarts delay then duration; with zero delay and nonzero duration a running pulse stays active and restarts its duration.
// - User output register holds one level bit per output port.
// - A user level bit drives its port only when the port is user set.
// - Input state register returns the level of each of four input ports.
`timescale 1ns/1ps
module strobe_pio
    import strobe_pio_pkg::*;
(
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst,
    // Register port
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wrData,
    input  wire logic              wrEn,
    input  wire logic              rdEn,
    output logic      [DATA_W-1:0] rdData,
    // Camera event
    input  wire logic              exposureStart,
    // Physical ports
    input  wire logic [3:0]        inPins,
    output logic      [3:0]        outPins
);

    typedef struct packed {
        phase_t [NUM_CH-1:0]              phase;
        logic   [NUM_CH-1:0][VAL_W-1:0]   count;
        logic   [NUM_CH-1:0][CTRL_W-1:0]  ctrl;
        logic   [3:0]                     userOut;
        logic   [3:0]                     portCfg;
        logic   [15:0]                    timeBase;
        logic   [3:0]                     inMeta;
        logic   [3:0]                     inSync;
        logic   [DATA_W-1:0]              rdData;
    } state_t;

    state_t          st_r;
    state_t          st_nxt;
    logic [NUM_CH-1:0] active;
    logic [NUM_CH-1:0] strobeLvl;
    time_base_if     tbus ();

    assign tbus.dlyMult = st_r.timeBase[TB_DLY_LSB +: MULT_W];
    assign tbus.durMult = st_r.timeBase[TB_DUR_LSB +: MULT_W];
    assign tbus.restart = exposureStart;

    time_base_gen u_time_base (
        .sys_clk (sys_clk),
        .rst     (rst),
        .tb      (tbus.gen)
    );

    always_comb begin
        logic [VAL_W-1:0] dly;
        logic [VAL_W-1:0] dur;
        dly    = '0;
        dur    = '0;
        st_nxt = st_r;
        // Pins are asynchronous to sys_clk; only the second stage is read
        st_nxt.inMeta = inPins;
        st_nxt.inSync = st_r.inMeta;
        st_nxt.rdData = '0;

        if (wrEn) begin
            if (addr < STROBE_CTRL_END && addr[1:0] == 2'b00) begin
                st_nxt.ctrl[addr[3:2]] = wrData[CTRL_W-1:0];
            end else if (addr == USER_OUT_OFS) begin
                st_nxt.userOut = wrData[3:0];
            end else if (addr == PORT_CFG_OFS) begin
                st_nxt.portCfg = wrData[3:0];
            end else if (addr == TIME_BASE_OFS) begin
                st_nxt.timeBase = wrData[15:0];
            end
        end

        // Unmapped reads return zero
        if (rdEn) begin
            if (addr < STROBE_CTRL_END && addr[1:0] == 2'b00) begin
                st_nxt.rdData = DATA_W'(st_r.ctrl[addr[3:2]]);
            end else if (addr == USER_OUT_OFS) begin
                st_nxt.rdData = DATA_W'(st_r.userOut);
            end else if (addr == INPUT_STATE_OFS) begin
                st_nxt.rdData = DATA_W'(st_r.inSync);
            end else if (addr == PORT_CFG_OFS) begin
                st_nxt.rdData = DATA_W'(st_r.portCfg);
            end else if (addr == TIME_BASE_OFS) begin
                st_nxt.rdData = DATA_W'(st_r.timeBase);
            end else if (addr == STATUS_OFS) begin
                st_nxt.rdData = DATA_W'(active);
            end
        end

        for (int i = 0; i < NUM_CH; i++) begin
            dly = st_r.ctrl[i][DLY_MSB:DLY_LSB];
            dur = st_r.ctrl[i][DUR_MSB:DUR_LSB];
            case (st_r.phase[i])
                PH_DELAY: begin
                    if (tbus.dlyTick) begin
                        if (st_r.count[i] == VAL_W'(1)) begin
                            st_nxt.phase[i] = (dur == '0) ? PH_IDLE : PH_ACTIVE;
                            st_nxt.count[i] = dur;
                        end else begin
                            st_nxt.count[i] = st_r.count[i] - VAL_W'(1);
                        end
                    end
                end
                PH_ACTIVE: begin
                    if (tbus.durTick) begin
                        if (st_r.count[i] == VAL_W'(1)) begin
                            st_nxt.phase[i] = PH_IDLE;
                        end else begin
                            st_nxt.count[i] = st_r.count[i] - VAL_W'(1);
                        end
                    end
                end
                default: begin
                    st_nxt.phase[i] = PH_IDLE;
                end
            endcase
            // A new exposure overrides whatever the channel was doing
            if (exposureStart) begin
                if (dly != '0) begin
                    st_nxt.phase[i] = PH_DELAY;
                    st_nxt.count[i] = dly;
                end else if (dur != '0) begin
                    st_nxt.phase[i] = PH_ACTIVE;
                    st_nxt.count[i] = dur;
                end else begin
                    st_nxt.phase[i] = PH_IDLE;
                end
            end
            if (!st_r.ctrl[i][EN_BIT]) begin
                st_nxt.phase[i] = PH_IDLE;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_r          <= '0;
            st_r.ctrl     <= {NUM_CH{STROBE_CTRL_RST}};
            st_r.userOut  <= USER_OUT_RST;
            st_r.portCfg  <= PORT_CFG_RST;
            st_r.timeBase <= TIME_BASE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdData = st_r.rdData;

    // Channel n is wired to port n only; there is no cross routing by design
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            assign active[g]    = (st_r.phase[g] == PH_ACTIVE);
            assign strobeLvl[g] = st_r.ctrl[g][POL_BIT] ? active[g] : !active[g];
            assign outPins[g]   = st_r.portCfg[g] ? strobeLvl[g] : st_r.userOut[g];

            chk_restart_delay: assert property (@(posedge sys_clk) disable iff (rst)
                exposureStart && st_r.ctrl[g][EN_BIT] && st_r.ctrl[g][DLY_MSB:DLY_LSB] != '0
                |=> st_r.phase[g] == PH_DELAY && st_r.count[g] == $past(st_r.ctrl[g][DLY_MSB:DLY_LSB]))
                else $error("channel did not restart its delay");

            chk_zero_delay: assert property (@(posedge sys_clk) disable iff (rst)
                exposureStart && st_r.ctrl[g][EN_BIT] && st_r.ctrl[g][DLY_MSB:DLY_LSB] == '0
                && st_r.ctrl[g][DUR_MSB:DUR_LSB] != '0 |=> active[g])
                else $error("zero delay did not go active next cycle");

            chk_zero_duration: assert property (@(posedge sys_clk) disable iff (rst)
                st_r.phase[g] == PH_DELAY && st_r.ctrl[g][DUR_MSB:DUR_LSB] == '0
                && !exposureStart |=> !active[g])
                else $error("zero duration produced a pulse");

            chk_disabled_idle: assert property (@(posedge sys_clk) disable iff (rst)
                !st_r.ctrl[g][EN_BIT] |=> st_r.phase[g] == PH_IDLE)
                else $error("disabled channel not idle");

            chk_delay_to_active: assert property (@(posedge sys_clk) disable iff (rst)
                st_r.phase[g] == PH_DELAY && tbus.dlyTick && st_r.count[g] == VAL_W'(1)
                && !exposureStart && st_r.ctrl[g][EN_BIT] && st_r.ctrl[g][DUR_MSB:DUR_LSB] != '0
                |=> active[g] && st_r.count[g] == $past(st_r.ctrl[g][DUR_MSB:DUR_LSB]))
                else $error("delay end did not start the pulse");

            chk_active_hold: assert property (@(posedge sys_clk) disable iff (rst)
                active[g] && !tbus.durTick && !exposureStart && st_r.ctrl[g][EN_BIT]
                |=> active[g] && $stable(st_r.count[g]))
                else $error("pulse ended without a duration tick");

            chk_pin_level: assert property (@(posedge sys_clk) disable iff (rst)
                st_r.portCfg[g] && st_r.phase[g] == PH_IDLE
                |-> outPins[g] == !st_r.ctrl[g][POL_BIT])
                else $error("idle strobe pin not at inactive level");

            chk_user_level: assert property (@(posedge sys_clk) disable iff (rst)
                wrEn && addr == USER_OUT_OFS && !st_r.portCfg[g] && !(wrEn && addr == PORT_CFG_OFS)
                |=> outPins[g] == $past(wrData[g]))
                else $error("user level not on its port");
        end
    endgenerate

    chk_input_read: assert property (@(posedge sys_clk) disable iff (rst)
        rdEn && addr == INPUT_STATE_OFS |=> rdData == DATA_W'($past(st_r.inSync)))
        else $error("input state read mismatch");

    chk_base_reset: assert property (@(posedge sys_clk)
        rst |=> st_r.timeBase == TIME_BASE_RST)
        else $error("time base not at default after reset");

    cov_full_pulse: cover property (@(posedge sys_clk) disable iff (rst)
        st_r.phase[0] == PH_DELAY ##1 st_r.phase[0] == PH_ACTIVE);
    cov_restart: cover property (@(posedge sys_clk) disable iff (rst)
        active[0] && exposureStart);
    cov_user_out: cover property (@(posedge sys_clk) disable iff (rst)
        !st_r.portCfg[2] && outPins[2]);
    cov_low_pulse: cover property (@(posedge sys_clk) disable iff (rst)
        st_r.portCfg[3] && active[3] && !outPins[3]);

endmodule : strobe_pio

/* strobe_partner.sv */
// Lamp and input equipment model at the physical ports
`timescale 1ns/1ps
module strobe_partner (
    // Clock
    input  wire logic       sys_clk,
    // Ports of the block
    input  wire logic [3:0] outPins,
    output logic      [3:0] inPins,
    // Bench control
    input  wire logic [3:0] level,
    input  wire logic       clr,
    output logic      [7:0] flashCnt_r
);
    logic prev_r;
    // Input switches hold steady levels; bounce is not modelled
    assign inPins = level;
    // Lamp on port 0 counts flashes, so a cut-short pulse still shows up
    always_ff @(posedge sys_clk) begin
        prev_r <= outPins[0];
        if (clr) begin
            flashCnt_r <= 8'h00;
        end else if (outPins[0] && !prev_r) begin
            flashCnt_r <= flashCnt_r + 8'h01;
        end
    end
endmodule : strobe_partner

/* strobe_pio_tb_top.sv */
// Self-checking bench for the strobe and parallel port block
`timescale 1ns/1ps
module strobe_pio_tb_top;
    import strobe_pio_pkg::*;
    logic              sys_clk;
    logic              rst;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wrData;
    logic              wrEn;
    logic              rdEn;
    logic [DATA_W-1:0] rdData;
    logic              exposureStart;
    logic [3:0]        inPins;
    logic [3:0]        outPins;
    logic [3:0]        level;
    logic              clr;
    logic [7:0]        flashCnt;
    int                n_fail;
    int                n_checks;
    int                dl;
    int                wd;

    strobe_pio dut_u (.sys_clk(sys_clk), .rst(rst), .addr(addr), .wrData(wrData),
        .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .exposureStart(exposureStart),
        .inPins(inPins), .outPins(outPins));
    strobe_partner lamp_u (.sys_clk(sys_clk), .outPins(outPins), .inPins(inPins),
        .level(level), .clr(clr), .flashCnt_r(flashCnt));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    function automatic logic [31:0] cv(input logic en, input logic pol, input logic [11:0] dly,
        input logic [11:0] dur);
        return {6'h00, en, pol, dly, dur};
    endfunction : cv

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic chkr(input int v, input int lo, input int hi);
        chk(32'(v >= lo && v <= hi), 32'h0000_0001);
    endtask : chkr

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        wrEn   <= 1'b1;
        addr   <= a;
        wrData <= d;
        @(posedge sys_clk);
        wrEn   <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        rdEn <= 1'b1;
        addr <= a;
        @(posedge sys_clk);
        rdEn <= 1'b0;
        #1;
        chk(rdData, exp);
    endtask : rd

    task automatic expo();
        @(posedge sys_clk);
        exposureStart <= 1'b1;
        @(posedge sys_clk);
        exposureStart <= 1'b0;
    endtask : expo

    // Cycles from exposure to active level, then cycles spent active
    task automatic pulse(input int ch, input logic act, output int d, output int w);
        expo();
        #1;
        d = 1;
        w = 0;
        while (outPins[ch] !== act && d < 1000) begin
            @(posedge sys_clk);
            #1;
            d++;
        end
        while (outPins[ch] === act && w < 3000) begin
            @(posedge sys_clk);
            #1;
            w++;
        end
    endtask : pulse

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict

    // A hang counts against the run; the tests need about 25 us
    initial begin
        #100_000;
        n_fail++;
        give_verdict();
    end

    initial begin
        n_fail = 0;
        n_checks = 0;
        rst = 1'b1;
        addr = 8'h00;
        wrData = 32'h0000_0000;
        wrEn = 1'b0;
        rdEn = 1'b0;
        exposureStart = 1'b0;
        level = 4'h5;
        clr = 1'b1;
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        clr <= 1'b0;
        for (int i = 0; i < 4; i++) rd(8'(4 * i), 32'h0000_0000);
        rd(USER_OUT_OFS, 32'h0000_0000);
        rd(TIME_BASE_OFS, 32'h0000_0101);
        chk(32'(outPins), 32'h0000_0000);
        $display("test reset values done");
        for (int i = 0; i < 4; i++) begin
            wr(8'(4 * i), 32'hFFFF_FFFF);
            rd(8'(4 * i), 32'h03FF_FFFF);
            wr(8'(4 * i), 32'h0000_0000);
        end
        wr(INPUT_STATE_OFS, 32'hFFFF_FFFF);
        rd(INPUT_STATE_OFS, 32'h0000_0005);
        // Read data stand for one cycle only, then fall back to zero
        @(posedge sys_clk);
        #1;
        chk(rdData, 32'h0000_0000);
        level <= 4'hA;
        repeat (3) @(posedge sys_clk);
        rd(INPUT_STATE_OFS, 32'h0000_000A);
        rd(8'hFC, 32'h0000_0000);
        $display("test register access done");
        wr(USER_OUT_OFS, 32'h0000_0005);
        #1;
        chk(32'(outPins), 32'h0000_0005);
        wr(PORT_CFG_OFS, 32'h0000_000F);
        #1;
        chk(32'(outPins), 32'h0000_000F);
        wr(8'h0C, cv(1'b1, 1'b0, 12'h000, 12'h001));
        expo();
        #1;
        chk(32'(outPins), 32'h0000_0007);
        rd(STATUS_OFS, 32'h0000_0008);
        rd(PORT_CFG_OFS, 32'h0000_000F);
        repeat (200) @(posedge sys_clk);
        #1;
        chk(32'(outPins), 32'h0000_000F);
        wr(8'h0C, 32'h0000_0000);
        $display("test port routing done");
        wr(PORT_CFG_OFS, 32'h0000_0001);
        wr(8'h00, cv(1'b1, 1'b1, 12'h000, 12'h001));
        #1;
        chk(32'(outPins), 32'h0000_0004);
        pulse(0, 1'b1, dl, wd);
        chkr(dl, 1, 1);
        chkr(wd, 194, 197);
        wr(8'h00, cv(1'b1, 1'b1, 12'h001, 12'h001));
        pulse(0, 1'b1, dl, wd);
        chkr(dl, 195, 197);
        $display("test strobe timing done");
        wr(8'h00, cv(1'b1, 1'b1, 12'h000, 12'h000));
        pulse(0, 1'b1, dl, wd);
        chkr(dl, 1000, 1000);
        wr(8'h00, cv(1'b0, 1'b1, 12'h000, 12'h001));
        pulse(0, 1'b1, dl, wd);
        chkr(dl, 1000, 1000);
        $display("test no pulse done");
        wr(8'h00, cv(1'b1, 1'b1, 12'h001, 12'h004));
        clr <= 1'b1;
        @(posedge sys_clk);
        clr <= 1'b0;
        expo();
        repeat (300) @(posedge sys_clk);
        pulse(0, 1'b1, dl, wd);
        chkr(dl, 195, 197);
        chkr(wd, 779, 783);
        chk(32'(flashCnt), 32'h0000_0002);
        $display("test restart done");
        wr(TIME_BASE_OFS, 32'h0000_0202);
        wr(8'h00, cv(1'b1, 1'b1, 12'h001, 12'h001));
        pulse(0, 1'b1, dl, wd);
        chkr(dl, 389, 393);
        chkr(wd, 389, 393);
        $display("test time base done");
        // A reset in mid-run must bring back the default time base and user levels
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        rd(TIME_BASE_OFS, 32'h0000_0101);
        chk(32'(outPins), 32'h0000_0000);
        $display("test second reset done");
        give_verdict();
    end
endmodule : strobe_pio_tb_top
